//--- design/qepv_sync.sv
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Velocity capture runs only while position tracking is also enabled.
// - Optional swap of the two phase lines before decoding.
// - Signal format zero decodes two quadrature lines, edge order gives direction.
// - Other format: first line is step clock, second is direction level.
// - Edge select counts first-phase edges only, or edges of both phases.
// - First phase leading counts up, second phase leading counts down.
// - Two edges on one phase without the other means direction changed.
// - Wrap option one: index clears position; either option takes backward from zero to the limit.
// - Wrap option zero: index only raises its event; either option wraps at the limit.
// - Velocity counts the same selected edges as the position tracker.
// - Timer counts down from load, raises event at zero, reloads.
// - Events: phase error, direction change, index pulse, timer expiry.
// - Each event has mask, raw status, masked status and clear.
// - Edges into velocity accumulator divided by two to the 3-bit prescale.
`timescale 1ns/10ps
package qepv_pkg;
  localparam int POS_W = 32;
  localparam int IRQ_W = 4;
  localparam int PRE_W = 8;
  localparam int DIV_W = 3;
  localparam int LINE_W = 3;
  // Line order in the synchroniser
  localparam int LN_A = 0;
  localparam int LN_B = 1;
  localparam int LN_IDX = 2;
  // Event bits
  localparam int EV_PHASE = 0;
  localparam int EV_DIR = 1;
  localparam int EV_INDEX = 2;
  localparam int EV_TIMER = 3;
  localparam logic [POS_W-1:0] POS_ZERO = 32'h0000_0000;
  localparam logic [POS_W-1:0] POS_ONE = 32'h0000_0001;
  localparam logic [PRE_W-1:0] PRE_ONE = 8'h01;
  localparam logic [PRE_W-1:0] PRE_ZERO = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_ZERO = 4'h0;

  typedef struct packed {
    logic             position_enable;
    logic             velocity_enable;
    logic             swap_phases;
    logic             signal_format_select;
    logic             edge_select_option;
    logic             position_wrap_option;
    logic [DIV_W-1:0] velocity_prescale;
  } qepv_ctrl_t;
endpackage

//////////////////////////////////////////////////////////////////////////////
module qepv_sync #(
  parameter int WIDTH = 3
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Asynchronous lines in
  input  wire logic [WIDTH-1:0] raw_in,
  // Filtered level and one-cycle change pulse
  output logic      [WIDTH-1:0] level,
  output logic      [WIDTH-1:0] change
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;
  logic [WIDTH-1:0] next_level;

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      change[i] = (s2[i] == s3[i]) && (s3[i] != level[i]);
      next_level[i] = change[i] ? s3[i] : level[i];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      level <= '0;
    end else begin
      s1 <= raw_in;
      s2 <= s1;
      s3 <= s2;
      level <= next_level;
    end
  end
endmodule

//--- design/qepv_decoder.sv
`timescale 1ns/10ps
module qepv_decoder (
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            reset,
  // Encoder lines
  input  wire logic                            first_quadrature_line,
  input  wire logic                            second_quadrature_line,
  input  wire logic                            home_marker_line,
  // Configuration
  input  wire qepv_pkg::qepv_ctrl_t            decoder_control,
  input  wire logic [qepv_pkg::POS_W-1:0]      position_limit_value,
  input  wire logic [qepv_pkg::POS_W-1:0]      velocity_period_load,
  // Event control
  input  wire logic [qepv_pkg::IRQ_W-1:0]      interrupt_mask,
  input  wire logic [qepv_pkg::IRQ_W-1:0]      interrupt_clear,
  // Position and velocity
  output logic      [qepv_pkg::POS_W-1:0]      position,
  output logic                                 direction,
  output logic      [qepv_pkg::POS_W-1:0]      velocity_result,
  output logic      [qepv_pkg::POS_W-1:0]      velocity_accumulator,
  output logic      [qepv_pkg::POS_W-1:0]      velocity_timer,
  // Event status
  output logic      [qepv_pkg::IRQ_W-1:0]      raw_status,
  output logic      [qepv_pkg::IRQ_W-1:0]      masked_status,
  output logic                                 interrupt_request
);
  logic [qepv_pkg::LINE_W-1:0] lvl;
  logic [qepv_pkg::LINE_W-1:0] chg;
  logic [qepv_pkg::LINE_W-1:0] now_lvl;
  logic                        a_lvl;
  logic                        b_lvl;
  logic                        a_chg;
  logic                        b_chg;
  logic                        quad;
  logic                        step;
  logic                        step_fwd;
  logic                        phase_err;
  logic                        dir_event;
  logic                        idx_rise;
  logic                        idx_clear;
  logic                        vel_run;
  logic                        period_end;
  logic [qepv_pkg::PRE_W-1:0]  pre_cnt;
  logic [qepv_pkg::PRE_W-1:0]  pre_top;
  logic [qepv_pkg::PRE_W-1:0]  next_pre_cnt;
  logic [qepv_pkg::IRQ_W-1:0]  events;
  logic [qepv_pkg::POS_W-1:0]  next_position;
  logic                        next_direction;
  logic [qepv_pkg::POS_W-1:0]  next_result;
  logic [qepv_pkg::POS_W-1:0]  next_accum;
  logic [qepv_pkg::POS_W-1:0]  next_timer;
  logic [qepv_pkg::IRQ_W-1:0]  next_raw;

  qepv_sync #(
    .WIDTH (qepv_pkg::LINE_W)
  ) u_sync (
    .clock  (clock),
    .reset  (reset),
    .raw_in ({home_marker_line, second_quadrature_line, first_quadrature_line}),
    .level  (lvl),
    .change (chg)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Edge decode
  always_comb begin
    // Filtered level still holds the old value while its change pulse is high
    now_lvl = lvl ^ chg;
    a_lvl = decoder_control.swap_phases ? now_lvl[qepv_pkg::LN_B] : now_lvl[qepv_pkg::LN_A];
    b_lvl = decoder_control.swap_phases ? now_lvl[qepv_pkg::LN_A] : now_lvl[qepv_pkg::LN_B];
    a_chg = decoder_control.swap_phases ? chg[qepv_pkg::LN_B] : chg[qepv_pkg::LN_A];
    b_chg = decoder_control.swap_phases ? chg[qepv_pkg::LN_A] : chg[qepv_pkg::LN_B];
    quad = !decoder_control.signal_format_select;
    phase_err = decoder_control.position_enable && quad && a_chg && b_chg;
    if (quad) begin
      step = decoder_control.position_enable && !phase_err &&
             (a_chg || (b_chg && decoder_control.edge_select_option));
      step_fwd = a_chg ? (a_lvl ^ b_lvl) : !(a_lvl ^ b_lvl);
    end else begin
      // step clock on rising edge, low direction level counts up
      step = decoder_control.position_enable && a_chg && a_lvl;
      step_fwd = !b_lvl;
    end
    // repeated edge on one phase flips the sense
    dir_event = decoder_control.position_enable && !phase_err && (a_chg || b_chg) &&
                (quad || step) && (step_fwd != direction);
    idx_rise = chg[qepv_pkg::LN_IDX] && now_lvl[qepv_pkg::LN_IDX] && decoder_control.position_enable;
    // index clears position only with wrap option one, it still raises its event
    idx_clear = idx_rise && decoder_control.position_wrap_option;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Position
  always_comb begin
    next_position = position;
    next_direction = dir_event ? step_fwd : direction;
    if (idx_clear) begin
      next_position = qepv_pkg::POS_ZERO;
    end else if (step && step_fwd) begin
      next_position = (position >= position_limit_value) ? qepv_pkg::POS_ZERO : position + qepv_pkg::POS_ONE;
    end else if (step) begin
      // backward from zero lands on the limit
      next_position = (position == qepv_pkg::POS_ZERO) ? position_limit_value : position - qepv_pkg::POS_ONE;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      position <= '0;
      direction <= 1'b0;
    end else begin
      position <= next_position;
      direction <= next_direction;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Velocity
  always_comb begin
    vel_run = decoder_control.velocity_enable && decoder_control.position_enable;
    pre_top = (qepv_pkg::PRE_ONE << decoder_control.velocity_prescale) - qepv_pkg::PRE_ONE;
    period_end = vel_run && (velocity_timer == qepv_pkg::POS_ZERO);
    next_pre_cnt = pre_cnt;
    next_accum = velocity_accumulator;
    next_result = velocity_result;
    next_timer = velocity_timer - qepv_pkg::POS_ONE;
    if (!vel_run) begin
      next_pre_cnt = qepv_pkg::PRE_ZERO;
      next_accum = qepv_pkg::POS_ZERO;
      next_timer = velocity_period_load;
    end else begin
      if (period_end) begin
        next_result = velocity_accumulator;
        next_accum = qepv_pkg::POS_ZERO;
        next_timer = velocity_period_load;
      end
      if (step) begin
        if (pre_cnt >= pre_top) begin
          next_pre_cnt = qepv_pkg::PRE_ZERO;
          next_accum = next_accum + qepv_pkg::POS_ONE;
        end else begin
          next_pre_cnt = pre_cnt + qepv_pkg::PRE_ONE;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pre_cnt <= '0;
      velocity_accumulator <= '0;
      velocity_result <= '0;
      velocity_timer <= '0;
    end else begin
      pre_cnt <= next_pre_cnt;
      velocity_accumulator <= next_accum;
      velocity_result <= next_result;
      velocity_timer <= next_timer;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event status
  always_comb begin
    events = qepv_pkg::IRQ_ZERO;
    events[qepv_pkg::EV_PHASE] = phase_err;
    events[qepv_pkg::EV_DIR] = dir_event;
    events[qepv_pkg::EV_INDEX] = idx_rise;
    events[qepv_pkg::EV_TIMER] = period_end;
    next_raw = (raw_status & ~interrupt_clear) | events;
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      raw_status <= '0;
      masked_status <= '0;
      interrupt_request <= 1'b0;
    end else begin
      raw_status <= next_raw;
      masked_status <= next_raw & interrupt_mask;
      interrupt_request <= |(next_raw & interrupt_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_vel_needs_pos: assert property (!decoder_control.position_enable |=> velocity_accumulator == '0)
    else $error("velocity counted without position enable");
  a_count_up: assert property (step && step_fwd && !idx_clear && position < position_limit_value
    |=> position == $past(position) + qepv_pkg::POS_ONE)
    else $error("forward step did not increment");
  a_wrap_limit: assert property (step && step_fwd && !idx_clear && position == position_limit_value
    |=> position == '0)
    else $error("no wrap at limit");
  a_wrap_back: assert property (step && !step_fwd && !idx_clear && position == '0
    |=> position == $past(position_limit_value))
    else $error("backward from zero missed limit");
  a_index_clear: assert property (idx_clear |=> position == '0 ##0 raw_status[qepv_pkg::EV_INDEX])
    else $error("index did not clear position");
  a_phase_error: assert property (phase_err |=> raw_status[qepv_pkg::EV_PHASE] && $stable(position))
    else $error("phase error mishandled");
  a_b_only_ignored: assert property (quad && b_chg && !a_chg && !decoder_control.edge_select_option
    |-> !step)
    else $error("second phase counted in two-edge mode");
  a_period_copy: assert property (period_end |=> velocity_result == $past(velocity_accumulator)
    && velocity_timer == $past(velocity_period_load))
    else $error("period end copy or reload wrong");
  a_timer_down: assert property (vel_run && !period_end ##1 vel_run
    |-> velocity_timer == $past(velocity_timer) - qepv_pkg::POS_ONE)
    else $error("timer did not count down");
  a_set_sticky: assert property (|events |=> (raw_status & $past(events)) == $past(events))
    else $error("event lost against clear");
  a_mask_gate: assert property (masked_status == (raw_status & $past(interrupt_mask))
    && interrupt_request == |masked_status)
    else $error("request disagrees with masked status");

  c_wrap_forward: cover property (step && step_fwd && position == position_limit_value);
  c_dir_change: cover property (dir_event ##[1:50] dir_event);
  c_period_edges: cover property (period_end && velocity_accumulator != '0);
  c_index_hit: cover property (idx_clear && position != '0);
endmodule

//--- dv/qepv_encoder_model.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module qepv_encoder_model (
  // Clock
  input  wire logic clock,
  // Encoder lines
  output logic      line_a,
  output logic      line_b,
  output logic      line_idx
);
  logic [1:0] phase;
  initial begin
    phase = 2'h0;
    line_a = 1'b0;
    line_b = 1'b0;
    line_idx = 1'b0;
  end
  task automatic gap();
    repeat (8) @(negedge clock);
  endtask
  // gray order, first line leads forward
  task automatic turn(input logic fwd);
    phase = fwd ? phase + 2'h1 : phase - 2'h1;
    line_a = phase[1] ^ phase[0];
    line_b = phase[1];
    gap();
  endtask
  task automatic pulse(input logic fwd);
    line_b = ~fwd;
    gap();
    line_a = 1'b1;
    gap();
    line_a = 1'b0;
    gap();
  endtask
  // Both lines at once, a faulty encoder
  task automatic glitch();
    phase = phase + 2'h2;
    line_a = ~line_a;
    line_b = ~line_b;
    gap();
  endtask
  task automatic home();
    line_idx = 1'b1;
    gap();
    line_idx = 1'b0;
    gap();
  endtask
endmodule

//--- dv/qepv_decoder_bench.sv
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
module qepv_decoder_bench;
  logic                 clock, reset, line_a, line_b, line_idx, direction, irq;
  qepv_pkg::qepv_ctrl_t ctrl;
  logic [31:0]          limit, load, position, v_res, v_acc, v_tmr, pos, prev, seed;
  logic [3:0]           mask, clr, raw, masked;
  logic [31:0]          exp_q[$];
  int                   error_cnt, checked, cycles;

  qepv_encoder_model enc (.clock(clock), .line_a(line_a), .line_b(line_b), .line_idx(line_idx));
  qepv_decoder dut (.clock(clock), .reset(reset), .first_quadrature_line(line_a),
    .second_quadrature_line(line_b), .home_marker_line(line_idx), .decoder_control(ctrl),
    .position_limit_value(limit), .velocity_period_load(load), .interrupt_mask(mask),
    .interrupt_clear(clr), .position(position), .direction(direction), .velocity_result(v_res),
    .velocity_accumulator(v_acc), .velocity_timer(v_tmr), .raw_status(raw),
    .masked_status(masked), .interrupt_request(irq));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // Expected position worked out before the line moves
  task automatic go(input logic fwd);
    logic [1:0] np;
    logic       up;
    np = fwd ? enc.phase + 2'h1 : enc.phase - 2'h1;
    up = fwd ^ ctrl.swap_phases;
    if (ctrl.signal_format_select | ctrl.edge_select_option | (np[1] == enc.phase[1])) begin
      pos = up ? (pos >= limit ? 32'h0 : pos + 32'h1) : (pos == 32'h0 ? limit : pos - 32'h1);
      exp_q.push_back(pos);
    end
    if (ctrl.signal_format_select) enc.pulse(fwd);
    else enc.turn(fwd);
  endtask

  task automatic clear_all();
    clr = 4'hf;
    idle(1);
    clr = 4'h0;
    idle(1);
  endtask

  // Every position move is matched against the oldest note
  always @(negedge clock) begin
    if (!reset && position !== prev) begin
      if (exp_q.size() == 0) check(position, prev);
      else check(position, exp_q.pop_front());
    end
    prev = position;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      error_cnt++;
      conclude();
    end
  end

  initial begin
    {reset, ctrl, limit, load, mask, clr, pos, prev, error_cnt, checked, cycles} = '0;
    reset = 1'b1;
    limit = 32'h5;
    load = 32'hc8;
    seed = 32'h5bb2;
    idle(16);
    reset = 1'b0;
    check(position, 32'h0);
    check({23'h0, raw, masked, irq}, 32'h0);
    idle(8);
    ctrl.edge_select_option = 1'b1;
    enc.turn(1'b1);
    enc.turn(1'b0);
    ctrl.position_enable = 1'b1;
    repeat (8) go(1'b1);
    repeat (4) go(1'b0);
    idle(8);
    check({direction, raw[1]}, 2'h1);
    mask = 4'h2;
    idle(2);
    check({masked, irq}, 5'h5);
    clear_all();
    check({raw, irq}, 5'h0);
    ctrl.edge_select_option = 1'b0;
    repeat (4) go(1'b1);
    ctrl.edge_select_option = 1'b1;
    ctrl.swap_phases = 1'b1;
    repeat (4) go(1'b1);
    ctrl.swap_phases = 1'b0;
    repeat (16) begin
      seed = xs(seed);
      go(seed[0]);
    end
    while (enc.phase != 2'h0) go(1'b1);
    enc.glitch();
    idle(8);
    check(raw[0], 1'b1);
    while (enc.phase != 2'h0) go(1'b1);
    enc.home();
    check(raw[2], 1'b1);
    limit = 32'h7;
    ctrl.position_wrap_option = 1'b1;
    go(1'b1);
    // Note the clear before the pulse, it lands while home() still runs
    if (pos != 32'h0) exp_q.push_back(32'h0);
    pos = 32'h0;
    enc.home();
    go(1'b0);
    go(1'b1);
    ctrl.position_wrap_option = 1'b0;
    // Step line must start low, or the first pulse has no rising edge
    while (enc.phase != 2'h0) go(1'b1);
    ctrl.signal_format_select = 1'b1;
    go(1'b1);
    go(1'b0);
    go(1'b1);
    ctrl.signal_format_select = 1'b0;
    limit = 32'hff;
    clear_all();
    ctrl.velocity_enable = 1'b1;
    idle(2);
    repeat (6) go(1'b1);
    for (int i = 0; i < 300 && raw[3] !== 1'b1; i++) idle(1);
    check(v_res, 32'h6);
    check(32'(raw[3]), 32'h1);
    idle(1);
    check(v_tmr, load - 32'h1);
    load = 32'h00ff_ffff;
    for (int n = 0; n < 8; n++) begin
      ctrl.velocity_enable = 1'b0;
      idle(2);
      ctrl.velocity_prescale = n[2:0];
      ctrl.velocity_enable = 1'b1;
      repeat (1 << n) go(1'b1);
      idle(8);
      check(v_acc, 32'h1);
    end
    ctrl.position_enable = 1'b0;
    idle(4);
    check(v_tmr, load);
    check(v_acc, 32'h0);
    check(32'(exp_q.size()), 32'h0);
    conclude();
  end
endmodule
